// >>> shared/spm_pkg.sv
// constants for the serial-port pin-sharing block
// assumes one system clock and an active-high asynchronous reset
package spm_pkg;
    // ------------------------------------------------------------
    // pin indices
    // ------------------------------------------------------------
    localparam int NUM_PINS     = 7;
    localparam int NUM_GPIO     = 3;
    localparam int PIN_SEL0     = 0; // first SPI select / port_f_bit_seven
    localparam int PIN_TX0      = 1; // async0_transmit_out / second_spi_clock
    localparam int PIN_RX0      = 2; // async0_receive_in / second_spi_master_out
    localparam int PIN_TX1      = 3; // async1_transmit_out / second_spi_master_in
    localparam int PIN_RX1      = 4; // async1_receive_in / second_spi_select
    localparam int PIN_TX2      = 5; // async2_transmit_out / port_c_bit_six
    localparam int PIN_RX2      = 6; // async2_receive_in / port_c_bit_seven
    // ------------------------------------------------------------
    // gpio bit indices
    // ------------------------------------------------------------
    localparam int GPIO_F7      = 0;
    localparam int GPIO_C6      = 1;
    localparam int GPIO_C7      = 2;
    // ------------------------------------------------------------
    // reset values: function bit 1 selects the alternate function
    // ------------------------------------------------------------
    localparam logic [6:0] FUNC_RST     = 7'h60;
    localparam logic [2:0] GPIO_DIR_RST = 3'h2;
    localparam logic       IDLE_SELECT  = 1'h1;
    localparam logic       IDLE_RX      = 1'h1;
    localparam logic       IDLE_CLK     = 1'h0;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int PAD_LATENCY_CYC = 1;
endpackage

// >>> rtl/spm_pin_share.sv
// pin-sharing mux for the serial-port pin group
// assumes pad buffers resolve oe/out/in outside; core signals synchronous to clk_i
`timescale 1ns/1ps
module spm_pin_share #(
    parameter int NP = spm_pkg::NUM_PINS,
    parameter int NG = spm_pkg::NUM_GPIO
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [NP-1:0] pad_in_i,
    output logic      [NP-1:0] pad_out_o,
    output logic      [NP-1:0] pad_oe_o,
    input  wire logic          func_wr_i,
    input  wire logic [NP-1:0] func_wdata_i,
    output logic      [NP-1:0] func_sel_o,
    input  wire logic          dir_wr_i,
    input  wire logic [NG-1:0] dir_wdata_i,
    output logic      [NG-1:0] gpio_dir_o,
    input  wire logic [NG-1:0] gpio_out_i,
    output logic      [NG-1:0] gpio_in_o,
    input  wire logic          spi0_master_i,
    output logic               spi0_select_o,
    output logic               spi0_arb_o,
    input  wire logic          spi1_master_i,
    input  wire logic          spi1_clk_i,
    input  wire logic          spi1_mosi_i,
    input  wire logic          spi1_miso_i,
    output logic               spi1_clk_o,
    output logic               spi1_mosi_o,
    output logic               spi1_miso_o,
    output logic               spi1_select_o,
    input  wire logic          async0_tx_i,
    input  wire logic          async1_tx_i,
    input  wire logic          async2_tx_i,
    output logic               async0_rx_o,
    output logic               async1_rx_o,
    output logic               async2_rx_o
);
    // ------------------------------------------------------------
    // configuration state
    // ------------------------------------------------------------
    logic [NP-1:0] func_ff;
    logic [NG-1:0] dir_ff;
    logic [NP-1:0] nxt_func;
    logic [NG-1:0] nxt_dir;

    assign nxt_func = func_wr_i ? func_wdata_i : func_ff;
    assign nxt_dir  = dir_wr_i ? dir_wdata_i : dir_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            func_ff <= spm_pkg::FUNC_RST;
            dir_ff  <= spm_pkg::GPIO_DIR_RST;
        end else begin
            func_ff <= nxt_func;
            dir_ff  <= nxt_dir;
        end
    end

    // ------------------------------------------------------------
    // function decode
    // ------------------------------------------------------------
    wire logic alt_f7  = func_ff[spm_pkg::PIN_SEL0];
    wire logic alt_sp1 = func_ff[spm_pkg::PIN_TX0];
    wire logic alt_c6  = func_ff[spm_pkg::PIN_TX2];
    wire logic alt_c7  = func_ff[spm_pkg::PIN_RX2];
    wire logic sel1_in = pad_in_i[spm_pkg::PIN_RX1];
    // slave selected only while its select pin is low and the pin is in spi use
    wire logic sp1_selected = func_ff[spm_pkg::PIN_RX1] & ~sel1_in;

    // ------------------------------------------------------------
    // pad drive selection
    // ------------------------------------------------------------
    logic [NP-1:0] nxt_out;
    logic [NP-1:0] nxt_oe;

    // select pin never driven in spi use: input for both roles
    assign nxt_out[spm_pkg::PIN_SEL0] = gpio_out_i[spm_pkg::GPIO_F7];
    assign nxt_oe[spm_pkg::PIN_SEL0]  = alt_f7 & dir_ff[spm_pkg::GPIO_F7];

    assign nxt_out[spm_pkg::PIN_TX0] = alt_sp1 ? spi1_clk_i : async0_tx_i;
    assign nxt_oe[spm_pkg::PIN_TX0]  = ~alt_sp1 | spi1_master_i;

    // clock and data share one register stage, so the lead of data is kept
    assign nxt_out[spm_pkg::PIN_RX0] = spi1_mosi_i;
    assign nxt_oe[spm_pkg::PIN_RX0]  = func_ff[spm_pkg::PIN_RX0] & spi1_master_i;

    assign nxt_out[spm_pkg::PIN_TX1] = func_ff[spm_pkg::PIN_TX1] ? spi1_miso_i : async1_tx_i;
    assign nxt_oe[spm_pkg::PIN_TX1]  = func_ff[spm_pkg::PIN_TX1]
                                     ? (~spi1_master_i & sp1_selected)
                                     : 1'h1;

    assign nxt_out[spm_pkg::PIN_RX1] = 1'h0;
    assign nxt_oe[spm_pkg::PIN_RX1]  = 1'h0;

    assign nxt_out[spm_pkg::PIN_TX2] = alt_c6 ? gpio_out_i[spm_pkg::GPIO_C6] : async2_tx_i;
    assign nxt_oe[spm_pkg::PIN_TX2]  = alt_c6 ? dir_ff[spm_pkg::GPIO_C6] : 1'h1;

    assign nxt_out[spm_pkg::PIN_RX2] = gpio_out_i[spm_pkg::GPIO_C7];
    assign nxt_oe[spm_pkg::PIN_RX2]  = alt_c7 & dir_ff[spm_pkg::GPIO_C7];

    // ------------------------------------------------------------
    // inputs toward the cores; idle values when a pin is taken away, but the gpio inputs always follow their pins
    // ------------------------------------------------------------
    wire logic pin0 = pad_in_i[spm_pkg::PIN_SEL0];
    wire logic nxt_spi0_sel = alt_f7 ? spm_pkg::IDLE_SELECT : pin0;
    // select pin only means arbitration while master
    wire logic nxt_spi0_arb = ~alt_f7 & spi0_master_i & ~pin0;
    wire logic nxt_sp1_clk  = (alt_sp1 & ~spi1_master_i)
                            ? pad_in_i[spm_pkg::PIN_TX0] : spm_pkg::IDLE_CLK;
    wire logic nxt_sp1_mosi = func_ff[spm_pkg::PIN_RX0] & ~spi1_master_i
                            & pad_in_i[spm_pkg::PIN_RX0];
    wire logic nxt_sp1_miso = func_ff[spm_pkg::PIN_TX1] & spi1_master_i
                            & pad_in_i[spm_pkg::PIN_TX1];
    wire logic nxt_sp1_sel  = func_ff[spm_pkg::PIN_RX1] ? sel1_in : spm_pkg::IDLE_SELECT;
    wire logic nxt_rx0 = func_ff[spm_pkg::PIN_RX0] ? spm_pkg::IDLE_RX : pad_in_i[spm_pkg::PIN_RX0];
    wire logic nxt_rx1 = func_ff[spm_pkg::PIN_RX1] ? spm_pkg::IDLE_RX : sel1_in;
    wire logic nxt_rx2 = alt_c7 ? spm_pkg::IDLE_RX : pad_in_i[spm_pkg::PIN_RX2];
    wire logic [NG-1:0] nxt_gpio_in = {pad_in_i[spm_pkg::PIN_RX2],
                                       pad_in_i[spm_pkg::PIN_TX2],
                                       pin0};

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pad_out_o <= '0;
            pad_oe_o  <= '0;
        end else begin
            pad_out_o <= nxt_out;
            pad_oe_o  <= nxt_oe;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            spi0_select_o <= spm_pkg::IDLE_SELECT;
            spi0_arb_o    <= 1'h0;
            spi1_clk_o    <= spm_pkg::IDLE_CLK;
            spi1_mosi_o   <= 1'h0;
            spi1_miso_o   <= 1'h0;
            spi1_select_o <= spm_pkg::IDLE_SELECT;
        end else begin
            spi0_select_o <= nxt_spi0_sel;
            spi0_arb_o    <= nxt_spi0_arb;
            spi1_clk_o    <= nxt_sp1_clk;
            spi1_mosi_o   <= nxt_sp1_mosi;
            spi1_miso_o   <= nxt_sp1_miso;
            spi1_select_o <= nxt_sp1_sel;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            async0_rx_o <= spm_pkg::IDLE_RX;
            async1_rx_o <= spm_pkg::IDLE_RX;
            async2_rx_o <= spm_pkg::IDLE_RX;
            gpio_in_o   <= '0;
        end else begin
            async0_rx_o <= nxt_rx0;
            async1_rx_o <= nxt_rx1;
            async2_rx_o <= nxt_rx2;
            gpio_in_o   <= nxt_gpio_in;
        end
    end

    assign func_sel_o = func_ff;
    assign gpio_dir_o = dir_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_slave_deselected;
        func_ff[spm_pkg::PIN_TX1] && !spi1_master_i && sel1_in;
    endsequence

    sequence s_slave_selected;
        func_ff[spm_pkg::PIN_TX1] && func_ff[spm_pkg::PIN_RX1] && !spi1_master_i && !sel1_in;
    endsequence

    sel_pin_input_a: assert property (!alt_f7 |=> !pad_oe_o[spm_pkg::PIN_SEL0])
        else $error("select pin driven while in spi use");
    arb_master_a: assert property (!alt_f7 && !spi0_master_i |=> !spi0_arb_o)
        else $error("arbitration flagged outside master mode");
    clk_dir_a: assert property (alt_sp1
        |=> pad_oe_o[spm_pkg::PIN_TX0] == $past(spi1_master_i))
        else $error("spi clock direction wrong for role");
    miso_float_a: assert property (s_slave_deselected |=> !pad_oe_o[spm_pkg::PIN_TX1])
        else $error("slave data driven while not selected");
    mosi_align_a: assert property (spi1_master_i && alt_sp1 && func_ff[spm_pkg::PIN_RX0]
        |=> pad_out_o[spm_pkg::PIN_RX0] == $past(spi1_mosi_i)
            && pad_out_o[spm_pkg::PIN_TX0] == $past(spi1_clk_i))
        else $error("data and clock latency differ");
    reset_func_a: assert property ($fell(rst_i) |-> func_ff == spm_pkg::FUNC_RST)
        else $error("function select not at reset default");
    func_write_a: assert property (func_wr_i |=> func_ff == $past(func_wdata_i))
        else $error("function select write lost");
    dir_write_a: assert property (dir_wr_i ##1 !dir_wr_i[*2]
        |-> dir_ff == $past(dir_wdata_i, 2))
        else $error("gpio direction not held after write");
    c6_out_a: assert property (alt_c6 && dir_ff[spm_pkg::GPIO_C6]
        |=> pad_oe_o[spm_pkg::PIN_TX2])
        else $error("port C six not driven as output");
    c7_in_a: assert property (alt_c7 && !dir_ff[spm_pkg::GPIO_C7]
        |=> !pad_oe_o[spm_pkg::PIN_RX2])
        else $error("port C seven driven as input");
    async_rx_a: assert property (!func_ff[spm_pkg::PIN_RX1]
        |=> async1_rx_o == $past(sel1_in))
        else $error("async1 receive not routed");
    tx0_route_a: assert property (!alt_sp1 |=> pad_oe_o[spm_pkg::PIN_TX0]
        && pad_out_o[spm_pkg::PIN_TX0] == $past(async0_tx_i))
        else $error("async0 transmit not routed to its pin");
    miso_drive_a: assert property (s_slave_selected |=> pad_oe_o[spm_pkg::PIN_TX1])
        else $error("selected slave not driving its data out");
    sel0_route_a: assert property (!alt_f7
        |=> spi0_select_o == $past(pad_in_i[spm_pkg::PIN_SEL0]))
        else $error("select pin level not passed to first spi");
    slave_clk_a: assert property (alt_sp1 && !spi1_master_i
        |=> spi1_clk_o == $past(pad_in_i[spm_pkg::PIN_TX0]))
        else $error("slave clock input not taken from pin");
endmodule

// >>> test/spm_peer.sv
// far-side serial peer: resolves every shared pad from device and peer drive
// assumes the bench sets which pads the peer drives and at what level
`timescale 1ns/1ps
module spm_peer (
    input  wire logic       clk_i,
    input  wire logic [6:0] pad_out_i,
    input  wire logic [6:0] pad_oe_i,
    input  wire logic [6:0] peer_oe_i,
    input  wire logic [6:0] peer_val_i,
    output logic      [6:0] pad_in_o
);
    logic       float_ff = 1'h0;
    logic       sel_low;
    logic [6:0] drive;
    // released pads toggle so a stale level never passes for a real one
    always_ff @(posedge clk_i) begin
        float_ff <= ~float_ff;
    end
    assign sel_low = pad_oe_i[4] ? ~pad_out_i[4] : (peer_oe_i[4] & ~peer_val_i[4]);
    // slave data out floats while this peer is not selected
    assign drive = {peer_oe_i[6:4], peer_oe_i[3] & sel_low, peer_oe_i[2:0]};
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            pad_in_o[i] = pad_oe_i[i] ? pad_out_i[i] : (drive[i] ? peer_val_i[i] : float_ff);
        end
    end
endmodule

// >>> test/spm_pin_share_bench.sv
// self-checking bench for the serial-port pin-sharing block
// assumes the peer model resolves pads; inputs change on the falling edge
`timescale 1ns/1ps
module spm_pin_share_bench;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic       clk_i = 1'h0;
    logic       rst_i = 1'h1;
    logic       fwr = 1'h0, dwr = 1'h0, m0 = 1'h0, m1 = 1'h0;
    logic [6:0] fwd = 7'h60, pout, poe, pin, fsel, poe_p = 7'h00, pval = 7'h7F;
    logic [2:0] dwd = 3'h2, gout = 3'h0, gdir, gin, tx = 3'h7, rx, s1 = 3'h0;
    logic       sel0, arb, s1c, s1mo, s1mi, s1sel;
    int         err_total = 0, samples_checked = 0;
    initial forever #2.5 clk_i = ~clk_i;
    spm_pin_share u_spm_pin_share (.clk_i(clk_i), .rst_i(rst_i), .pad_in_i(pin),
        .pad_out_o(pout), .pad_oe_o(poe), .func_wr_i(fwr), .func_wdata_i(fwd),
        .func_sel_o(fsel), .dir_wr_i(dwr), .dir_wdata_i(dwd), .gpio_dir_o(gdir),
        .gpio_out_i(gout), .gpio_in_o(gin), .spi0_master_i(m0), .spi0_select_o(sel0),
        .spi0_arb_o(arb), .spi1_master_i(m1), .spi1_clk_i(s1[0]), .spi1_mosi_i(s1[1]),
        .spi1_miso_i(s1[2]), .spi1_clk_o(s1c), .spi1_mosi_o(s1mo), .spi1_miso_o(s1mi),
        .spi1_select_o(s1sel), .async0_tx_i(tx[0]), .async1_tx_i(tx[1]),
        .async2_tx_i(tx[2]), .async0_rx_o(rx[0]), .async1_rx_o(rx[1]), .async2_rx_o(rx[2]));
    spm_peer u_spm_peer (.clk_i(clk_i), .pad_out_i(pout), .pad_oe_i(poe),
        .peer_oe_i(poe_p), .peer_val_i(pval), .pad_in_o(pin));
    // ------------------------------------------------------------
    // shared tasks and scenarios
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic set_func(input logic [6:0] d);
        fwd = d;
        fwr = 1'h1;
        step(1);
        fwr = 1'h0;
        step(1);
    endtask
    task automatic t_defaults;
        tx = 3'h6;
        gout = 3'h2;
        poe_p = 7'h55;
        pval = 7'h6A;
        step(2);
        chk(poe, 7'h2A);
        chk(pout & 7'h2A, 7'h28);
        chk({3'h0, sel0, rx}, 7'h04);
        chk({4'h0, gin}, 7'h06);
    endtask
    task automatic t_arb;
        m0 = 1'h1;
        step(1);
        chk({5'h0, arb, sel0}, 7'h02);
        pval[0] = 1'h1;
        step(1);
        chk({5'h0, arb, sel0}, 7'h01);
        m0 = 1'h0;
        pval[0] = 1'h0;
        step(1);
        chk({5'h0, arb, sel0}, 7'h00);
    endtask
    task automatic t_spi;
        set_func(7'h7E);
        chk(fsel, 7'h7E);
        poe_p = 7'h19;
        m1 = 1'h1;
        s1 = 3'h0;
        step(1);
        // data launched one cycle ahead of the rising clock
        s1 = 3'h2;
        step(1);
        chk(pout & 7'h06, 7'h04);
        s1 = 3'h3;
        step(1);
        chk(pout & 7'h06, 7'h06);
        chk({poe & 7'h0E}, 7'h06);
        chk({6'h0, s1mi}, 7'h01);
        m1 = 1'h0;
        poe_p = 7'h17;
        pval = 7'h6E;
        s1 = 3'h4;
        step(2);
        chk({5'h0, s1c, s1mo}, 7'h03);
        chk(poe & 7'h0E, 7'h08);
        chk(pout & 7'h08, 7'h08);
        pval[4] = 1'h1;
        step(1);
        chk({poe[3], 5'h0, s1sel}, 7'h01);
    endtask
    task automatic t_async;
        set_func(7'h00);
        chk(fsel, 7'h00);
        tx = 3'h2;
        poe_p = 7'h40;
        pval = 7'h00;
        step(2);
        chk(pout & 7'h2A, 7'h08);
        chk({3'h0, poe[6:5], pout[5], rx[2]}, 7'h04);
    endtask
    task automatic t_gpio;
        gout = 3'h5;
        set_func(7'h61);
        poe_p = 7'h20;
        pval = 7'h00;
        dwd = 3'h5;
        dwr = 1'h1;
        step(1);
        dwr = 1'h0;
        step(2);
        chk({4'h0, gdir}, 7'h05);
        chk(poe & 7'h61, 7'h41);
        chk(pout & 7'h41, 7'h41);
        chk({3'h0, sel0, gin}, 7'h0D);
        rst_i = 1'h1;
        step(1);
        chk(fsel, 7'h60);
        chk({4'h0, gdir}, 7'h02);
        rst_i = 1'h0;
    endtask
    initial begin
        step(16);
        chk(fsel, 7'h60);
        chk({4'h0, gdir}, 7'h02);
        rst_i = 1'h0;
        t_defaults();
        t_arb();
        t_spi();
        t_async();
        t_gpio();
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        stop_test();
    end
endmodule
